// [core/pmr_pkg.sv]
// Shared constants and carrier types of the transceiver management registers
package pmr_pkg;

	// ********************************
	// Management frame
	// ********************************
	localparam logic [4:0] PHY_ADDR_A     = 5'h01;
	localparam logic [4:0] PHY_ADDR_B     = 5'h02;
	localparam logic [1:0] OP_READ        = 2'h2;
	localparam logic [1:0] OP_WRITE       = 2'h1;
	localparam int         PRE_BITS       = 32;
	localparam int         HDR_BITS       = 12;
	localparam int         DATA_BITS      = 16;

	// ********************************
	// Register addresses
	// ********************************
	localparam logic [4:0] REG_ID_UPPER   = 5'h02;
	localparam logic [4:0] REG_ID_LOWER   = 5'h03;
	localparam logic [4:0] REG_ADVERTISE  = 5'h04;
	localparam logic [4:0] REG_PARTNER    = 5'h05;
	localparam logic [4:0] REG_CABLE_DIAG = 5'h1D;
	localparam logic [4:0] REG_SPECIAL    = 5'h1F;

	// ********************************
	// Field positions
	// ********************************
	localparam int ADV_PAUSE_BIT  = 10;
	localparam int ADV_FD100_BIT  = 8;
	localparam int ADV_HD100_BIT  = 7;
	localparam int ADV_FD10_BIT   = 6;
	localparam int ADV_HD10_BIT   = 5;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam int CAB_START_BIT  = 15;
	localparam int CAB_RES_LSB    = 13;
	localparam int CAB_SHORT_BIT  = 12;
	localparam int SPC_POL_BIT    = 5;
	localparam int SPC_MDIX_BIT   = 4;
	localparam int SPC_FORCE_BIT  = 3;
	localparam int SPC_PWR_BIT    = 2;
	localparam int SPC_LOOP_BIT   = 1;
	localparam int SPC_RSV_BIT    = 0;
	localparam logic [1:0] CAB_FAILED = 2'h3;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_MHZ            = 10;
	localparam int CABLE_TIMEOUT_US   = 1000;
	localparam int CABLE_TIMEOUT_CYC  = CABLE_TIMEOUT_US * CLK_MHZ;

	// ********************************
	// Carrier types
	// ********************************
	typedef struct packed {
		logic pause;
		logic fd100;
		logic hd100;
		logic fd10;
		logic hd10;
	} pmr_adv_type;

	typedef struct packed {
		logic force_link;
		logic pwrsave_off;
		logic rem_loop;
		logic rsv0;
	} pmr_spc_type;

	typedef struct packed {
		logic lp_pause;
		logic lp_fd100;
		logic lp_hd100;
		logic lp_fd10;
		logic lp_hd10;
		logic pol_rev;
		logic mdix;
	} pmr_stat_type;

	typedef struct packed {
		logic       done;
		logic [1:0] result;
		logic       near_short_flag;
		logic [8:0] count;
	} pmr_cab_type;

	typedef struct packed {
		logic        wr;
		logic        port;
		pmr_adv_type adv;
		pmr_spc_type spc;
		logic        cab_start;
	} pmr_sw_type;

	localparam pmr_adv_type ADV_RESET = 5'h1F;
	localparam pmr_spc_type SPC_RESET = 4'h4;

	typedef enum logic [2:0] {
		ST_PRE   = 3'b000,
		ST_START = 3'b001,
		ST_HDR   = 3'b010,
		ST_TA    = 3'b011,
		ST_DATA  = 3'b100
	} pmr_state_type;

endpackage

// [core/pmr_mdio_sync.sv]
// Two-stage synchroniser for the management pins with clock edge detect
`timescale 1ns/1ps
module pmr_mdio_sync
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Pins
	input  wire logic mdc,
	input  wire logic mdio_in,
	// Synchronised view
	output logic      mdc_rise,
	output logic      mdio_bit
);

	typedef struct packed {
		logic [1:0] mdc_s;
		logic [1:0] dat_s;
		logic       mdc_old;
		logic       rise;
	} pmr_sync_type;

	// Pins idle high, so reset to that level and no false edge follows
	localparam pmr_sync_type SYNC_IDLE = '{mdc_s: 2'h3, dat_s: 2'h3,
		mdc_old: 1'h1, rise: 1'h0};

	pmr_sync_type s_q;
	pmr_sync_type s_d;

	// Only the second stage is looked at by the edge detector
	always_comb
	begin
		s_d         = s_q;
		s_d.mdc_s   = {s_q.mdc_s[0], mdc};
		s_d.dat_s   = {s_q.dat_s[0], mdio_in};
		s_d.mdc_old = s_q.mdc_s[1];
		s_d.rise    = s_q.mdc_s[1] & ~s_q.mdc_old;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_q <= SYNC_IDLE;
		else
			s_q <= s_d;
	end

	assign mdc_rise = s_q.rise;
	assign mdio_bit = s_q.dat_s[1];

endmodule // pmr_mdio_sync

// [core/pmr_regs.sv]
// Management register bank and frame engine of both copper transceivers
// Behaviour
// - Register 2 returns upper identifier half, read only, writes ignored.
// - Register 3 returns lower identifier half, read only, writes ignored.
// - Advertise bit 10 is writable pause advertisement, resets to one.
// - Advertise bits 8..5 select advertised speeds and duplex, writable.
// - Advertise selector reads 00001; next page and remote fault read zero.
// - Partner bit 10 shows partner pause ability, read only, reset zero.
// - Partner bits 8..5 show partner speed abilities, read only.
// - Writing one to cable bit 15 starts a test; cleared when done.
// - Cable bit 15 low means result, short and distance are valid.
// - Result field: 00 normal, 01 open, 10 short, 11 failed.
// - Cable bit 12 reads one when the short is under ten metres.
// - Nine-bit count gives distance to fault, about 0.4 m each.
// - Only the second transceiver has the cable register at 0x1D.
// - Special bit 5 shows reversed receive polarity, 10BASE-T only.
// - Special bit 4 reads one for crossed, zero for straight wiring.
// - Special bit 3 forces link pass when one, resets zero.
// - Special bit 2 is inverted: zero enables power saving, resets one.
// - Special bit 1 enables remote loopback on the port, resets zero.
// - Remote loopback returns receive data on the same port's transmit.
// - Fields share storage with switch port registers, both paths.
`timescale 1ns/1ps
module pmr_regs
#(
	parameter logic [15:0] ID_UPPER      = 16'hA5A5, // Arbitrary value
	parameter logic [15:0] ID_LOWER      = 16'h5A50, // Arbitrary value
	parameter int          CAB_TIMEOUT   = pmr_pkg::CABLE_TIMEOUT_CYC
)
(
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// Management pins
	input  wire logic                        mdc,
	input  wire logic                        mdio_in,
	output logic                             mdio_out,
	output logic                             mdio_oe,
	// Line status of both transceivers
	input  wire pmr_pkg::pmr_stat_type [1:0] stat,
	input  wire pmr_pkg::pmr_cab_type        cab,
	// Switch port register side
	input  wire pmr_pkg::pmr_sw_type         sw,
	// Controls to the transceivers
	output pmr_pkg::pmr_adv_type [1:0]       adv_out,
	output pmr_pkg::pmr_spc_type [1:0]       spc_out,
	output logic                             cab_start
);

	localparam int TW = $clog2(CAB_TIMEOUT + 1);
	localparam logic [TW-1:0] TO_LAST = TW'(CAB_TIMEOUT - 1);

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		pmr_pkg::pmr_state_type    st;
		logic [5:0]                cnt;
		logic [11:0]               hdr;
		logic [15:0]               sh;
		logic                      rd;
		logic                      wr;
		logic                      mdio_out;
		logic                      mdio_oe;
		pmr_pkg::pmr_adv_type [1:0] adv;
		pmr_pkg::pmr_spc_type [1:0] spc;
		logic                      busy;
		logic                      cab_start;
		logic [1:0]                result;
		logic                      near_short_flag;
		logic [8:0]                count;
		logic [TW-1:0]             timer;
	} pmr_core_type;

	localparam pmr_core_type CORE_RESET = '{
		st: pmr_pkg::ST_PRE, cnt: 6'h00, hdr: 12'h000, sh: 16'h0000,
		rd: 1'b0, wr: 1'b0, mdio_out: 1'b0, mdio_oe: 1'b0,
		adv: {pmr_pkg::ADV_RESET, pmr_pkg::ADV_RESET},
		spc: {pmr_pkg::SPC_RESET, pmr_pkg::SPC_RESET},
		busy: 1'b0, cab_start: 1'b0, result: 2'h0,
		near_short_flag: 1'b0, count: 9'h000, timer: '0};

	pmr_core_type s_q;
	pmr_core_type s_d;
	logic         mdc_rise;
	logic         mdio_bit;
	logic         commit_w;
	logic         load_w;
	logic [11:0]  hdr_w;
	logic [15:0]  data_w;

	pmr_mdio_sync u_sync
	(
		.clk      (clk),
		.rstn     (rstn),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.mdc_rise (mdc_rise),
		.mdio_bit (mdio_bit)
	);

	// ********************************
	// Read data
	// ********************************
	function automatic logic [15:0] rd_word(input logic p,
		input logic [4:0] ra, input pmr_core_type q);
		logic [15:0] w;
		w = 16'h0000;
		case (ra)
			pmr_pkg::REG_ID_UPPER: w = ID_UPPER;
			pmr_pkg::REG_ID_LOWER: w = ID_LOWER;
			pmr_pkg::REG_ADVERTISE:
			begin
				w[pmr_pkg::ADV_PAUSE_BIT] = q.adv[p].pause;
				w[pmr_pkg::ADV_FD100_BIT-:4] = q.adv[p][3:0];
				w[4:0] = pmr_pkg::ADV_SELECTOR;
			end
			pmr_pkg::REG_PARTNER:
			begin
				w[pmr_pkg::ADV_PAUSE_BIT] = stat[p].lp_pause;
				w[pmr_pkg::ADV_FD100_BIT-:4] = stat[p][5:2];
			end
			pmr_pkg::REG_CABLE_DIAG:
			begin
				if (p)
				begin
					w[pmr_pkg::CAB_START_BIT] = q.busy;
					w[pmr_pkg::CAB_RES_LSB+:2] = q.result;
					w[pmr_pkg::CAB_SHORT_BIT] = q.near_short_flag;
					w[8:0] = q.count;
				end
			end
			pmr_pkg::REG_SPECIAL:
			begin
				w[pmr_pkg::SPC_POL_BIT]   = stat[p].pol_rev;
				w[pmr_pkg::SPC_MDIX_BIT]  = stat[p].mdix;
				w[pmr_pkg::SPC_FORCE_BIT] = q.spc[p].force_link;
				w[pmr_pkg::SPC_PWR_BIT]   = q.spc[p].pwrsave_off;
				w[pmr_pkg::SPC_LOOP_BIT]  = q.spc[p].rem_loop;
				w[pmr_pkg::SPC_RSV_BIT]   = q.spc[p].rsv0;
			end
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		s_d = s_q;
		s_d.cab_start = 1'b0;
		commit_w = 1'b0;
		load_w = 1'b0;
		hdr_w = {s_q.hdr[10:0], mdio_bit};
		data_w = {s_q.sh[14:0], mdio_bit};
		// Cable test progress; a missing answer ends as a failed test
		if (s_q.busy)
		begin
			if (cab.done)
			begin
				s_d.busy = 1'b0;
				s_d.result = cab.result;
				s_d.near_short_flag = cab.near_short_flag;
				s_d.count = cab.count;
			end
			else if (s_q.timer == TO_LAST)
			begin
				s_d.busy = 1'b0;
				s_d.result = pmr_pkg::CAB_FAILED;
				s_d.near_short_flag = 1'b0;
				s_d.count = 9'h000;
			end
			else
				s_d.timer = s_q.timer + 1'b1;
		end
		// Switch side writes first so a same-cycle frame write wins
		if (sw.wr)
		begin
			s_d.adv[sw.port] = sw.adv;
			s_d.spc[sw.port] = sw.spc;
			if (sw.cab_start && sw.port && !s_d.busy)
			begin
				s_d.busy = 1'b1;
				s_d.timer = '0;
				s_d.cab_start = 1'b1;
			end
		end
		if (mdc_rise)
		begin
			case (s_q.st)
				pmr_pkg::ST_PRE:
				begin
					s_d.mdio_oe = 1'b0;
					if (mdio_bit)
					begin
						if (s_q.cnt != 6'(pmr_pkg::PRE_BITS))
							s_d.cnt = s_q.cnt + 6'h01;
					end
					else if (s_q.cnt == 6'(pmr_pkg::PRE_BITS))
						s_d.st = pmr_pkg::ST_START;
					else
						s_d.cnt = 6'h00;
				end
				pmr_pkg::ST_START:
				begin
					s_d.cnt = 6'h00;
					s_d.st = mdio_bit ? pmr_pkg::ST_HDR : pmr_pkg::ST_PRE;
				end
				pmr_pkg::ST_HDR:
				begin
					s_d.hdr = hdr_w;
					s_d.cnt = s_q.cnt + 6'h01;
					if (s_q.cnt == 6'(pmr_pkg::HDR_BITS - 1))
					begin
						s_d.st = pmr_pkg::ST_TA;
						s_d.cnt = 6'h00;
						// Other addresses run the frame out silently
						s_d.rd = (hdr_w[11:10] == pmr_pkg::OP_READ) &&
							((hdr_w[9:5] == pmr_pkg::PHY_ADDR_A) ||
							(hdr_w[9:5] == pmr_pkg::PHY_ADDR_B));
						s_d.wr = (hdr_w[11:10] == pmr_pkg::OP_WRITE) &&
							((hdr_w[9:5] == pmr_pkg::PHY_ADDR_A) ||
							(hdr_w[9:5] == pmr_pkg::PHY_ADDR_B));
						load_w = 1'b1;
						s_d.sh = rd_word(hdr_w[9:5] == pmr_pkg::PHY_ADDR_B,
							hdr_w[4:0], s_q);
					end
				end
				pmr_pkg::ST_TA:
				begin
					s_d.cnt = 6'h01;
					if (s_q.cnt == 6'h00)
					begin
						// Second turnaround bit is driven low on reads
						s_d.mdio_oe = s_q.rd;
						s_d.mdio_out = 1'b0;
					end
					else
					begin
						s_d.st = pmr_pkg::ST_DATA;
						s_d.cnt = 6'h00;
						if (s_q.rd)
						begin
							s_d.mdio_out = s_q.sh[15];
							s_d.sh = {s_q.sh[14:0], 1'b0};
						end
					end
				end
				pmr_pkg::ST_DATA:
				begin
					s_d.cnt = s_q.cnt + 6'h01;
					if (s_q.rd)
					begin
						s_d.mdio_out = s_q.sh[15];
						s_d.sh = {s_q.sh[14:0], 1'b0};
					end
					else
						s_d.sh = data_w;
					if (s_q.cnt == 6'(pmr_pkg::DATA_BITS - 1))
					begin
						s_d.st = pmr_pkg::ST_PRE;
						s_d.cnt = 6'h00;
						s_d.mdio_oe = 1'b0;
						s_d.mdio_out = 1'b0;
						s_d.rd = 1'b0;
						s_d.wr = 1'b0;
						commit_w = s_q.wr;
					end
				end
				default:
				begin
					s_d.st = pmr_pkg::ST_PRE;
					s_d.mdio_oe = 1'b0;
				end
			endcase
		end
		// Frame write lands in the shared storage; read-only words ignore it
		if (commit_w)
		begin
			case (s_q.hdr[4:0])
				pmr_pkg::REG_ADVERTISE:
					s_d.adv[s_q.hdr[9:5] == pmr_pkg::PHY_ADDR_B] = {
						data_w[pmr_pkg::ADV_PAUSE_BIT],
						data_w[pmr_pkg::ADV_FD100_BIT-:4]};
				pmr_pkg::REG_SPECIAL:
					s_d.spc[s_q.hdr[9:5] == pmr_pkg::PHY_ADDR_B] =
						data_w[pmr_pkg::SPC_FORCE_BIT-:4];
				pmr_pkg::REG_CABLE_DIAG:
				begin
					if ((s_q.hdr[9:5] == pmr_pkg::PHY_ADDR_B) &&
						data_w[pmr_pkg::CAB_START_BIT] && !s_d.busy)
					begin
						s_d.busy = 1'b1;
						s_d.timer = '0;
						s_d.cab_start = 1'b1;
					end
				end
				default: s_d.busy = s_d.busy;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_q <= CORE_RESET;
		else
			s_q <= s_d;
	end

	// ********************************
	// Outputs
	// ********************************
	assign mdio_out  = s_q.mdio_out;
	assign mdio_oe   = s_q.mdio_oe;
	assign adv_out   = s_q.adv;
	assign spc_out   = s_q.spc;
	assign cab_start = s_q.cab_start;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	adv_reset_a: assert property ($rose(rstn) |->
		s_q.adv[0] == pmr_pkg::ADV_RESET && s_q.adv[1] == pmr_pkg::ADV_RESET)
		else $error("advertise not at reset value");
	spc_reset_a: assert property ($rose(rstn) |->
		s_q.spc[0] == pmr_pkg::SPC_RESET && s_q.spc[1] == pmr_pkg::SPC_RESET)
		else $error("special control not at reset value");
	id_read_a: assert property (load_w && s_d.rd &&
		hdr_w[4:0] == pmr_pkg::REG_ID_UPPER |=> s_q.sh == ID_UPPER)
		else $error("upper identifier not loaded");
	adv_write_a: assert property (commit_w && !sw.wr &&
		s_q.hdr[4:0] == pmr_pkg::REG_ADVERTISE && s_q.hdr[9:5] ==
		pmr_pkg::PHY_ADDR_A |=> s_q.adv[0].fd100 == $past(data_w[8]) &&
		s_q.adv[0].pause == $past(data_w[10]))
		else $error("advertise write lost");
	ta_drive_a: assert property (mdc_rise && s_q.st == pmr_pkg::ST_TA &&
		s_q.cnt == 6'h00 && s_q.rd |=> mdio_oe && !mdio_out)
		else $error("turnaround not driven low");
	idle_quiet_a: assert property (s_q.st == pmr_pkg::ST_PRE &&
		$past(s_q.st) == pmr_pkg::ST_PRE |-> !mdio_oe)
		else $error("pin driven outside a read");
	cab_clear_a: assert property (s_q.busy && cab.done &&
		!s_d.cab_start |=> !s_q.busy ##0 s_q.result == $past(cab.result))
		else $error("cable test did not finish");
	cab_fail_a: assert property (s_q.busy && !cab.done &&
		s_q.timer == TO_LAST && !s_d.cab_start |=>
		!s_q.busy && s_q.result == 2'h3)
		else $error("timeout not reported as failed");
	cab_port_a: assert property (commit_w && !sw.wr && !s_q.busy &&
		s_q.hdr[9:5] == pmr_pkg::PHY_ADDR_A |=> !cab_start)
		else $error("first transceiver started a cable test");
	pol_read_a: assert property (load_w && s_d.rd &&
		hdr_w[4:0] == pmr_pkg::REG_SPECIAL |=>
		s_q.sh[5] == $past(stat[hdr_w[9:5] == pmr_pkg::PHY_ADDR_B].pol_rev))
		else $error("polarity status not read");
	read_frame_c: cover property (s_q.rd && commit_w == 1'b0 &&
		s_q.st == pmr_pkg::ST_DATA ##1 s_q.st == pmr_pkg::ST_PRE);
	write_frame_c: cover property (commit_w);
	cab_done_c: cover property (s_q.busy && cab.done);
	cab_timeout_c: cover property (s_q.busy && s_q.timer == TO_LAST);

endmodule // pmr_regs

// [verif/pmr_mgmt_model.sv]
// Station management controller model: clause 22 frames on the pins
`timescale 1ns/1ps
module pmr_mgmt_model
(
	// Clock
	input  wire logic clk,
	// Device side of the pin
	input  wire logic mdio_out,
	input  wire logic mdio_oe,
	// Controller side
	output logic      mdc,
	output logic      mdio_in
);
	logic drv_en;
	logic drv_d;
	int   half;

	initial
	begin
		mdc = 1'b1;
		drv_en = 1'b0;
		drv_d = 1'b0;
		half = 4;
	end

	// Released wire floats to the pull-up, never the last value
	assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_d : 1'b1);

	// Sample at the rising edge of the management clock
	task automatic bit_cyc(input logic en, input logic d,
		output logic smp);
		mdc <= 1'b0;
		drv_en <= en;
		drv_d <= d;
		repeat (half) @(posedge clk);
		smp = mdio_in;
		mdc <= 1'b1;
		repeat (half) @(posedge clk);
	endtask

	// Write drives the turnaround and data; read releases both
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [45:0] hdr;
		logic        w;
		logic        s;
		hdr = {32'hFFFFFFFF, 2'b01, op, pa, ra};
		w = (op == pmr_pkg::OP_WRITE);
		@(posedge clk);
		for (int i = 45; i >= 0; i--)
			bit_cyc(1'b1, hdr[i], s);
		bit_cyc(w, 1'b1, s);
		bit_cyc(w, 1'b0, s);
		for (int i = 15; i >= 0; i--)
		begin
			bit_cyc(w, wd[i], s);
			rd[i] = s;
		end
		bit_cyc(1'b0, 1'b1, s);
	endtask
endmodule // pmr_mgmt_model

// [verif/pmr_regs_tb.sv]
// Self-checking bench of the transceiver management registers
`timescale 1ns/1ps
module pmr_regs_tb;
	localparam int          CAB_TO = 1500;
	localparam logic [15:0] ID_U   = 16'hC3A1; // Arbitrary value
	localparam logic [15:0] ID_L   = 16'h5E72; // Arbitrary value

	logic                        clk;
	logic                        rstn;
	logic                        mdc;
	logic                        mdio_in;
	logic                        mdio_out;
	logic                        mdio_oe;
	pmr_pkg::pmr_stat_type [1:0] stat;
	pmr_pkg::pmr_cab_type        cab;
	pmr_pkg::pmr_sw_type         sw;
	pmr_pkg::pmr_adv_type [1:0]  adv_out;
	pmr_pkg::pmr_spc_type [1:0]  spc_out;
	logic                        cab_start;
	int                          n_fail;
	int                          n_tests;
	int                          n_starts;
	int                          cyc;
	logic [15:0]                 rv;

	pmr_regs #(.ID_UPPER(ID_U), .ID_LOWER(ID_L), .CAB_TIMEOUT(CAB_TO))
	dut_u (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .stat(stat), .cab(cab),
		.sw(sw), .adv_out(adv_out), .spc_out(spc_out),
		.cab_start(cab_start));

	pmr_mgmt_model mc_u (.clk(clk), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

	// ****************
	// Clock, watchdog
	// ****************
	always #50 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cab_start === 1'b1)
			n_starts++;
		if (cyc == 80000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] d);
		logic [15:0] x;
		mc_u.xfer(pmr_pkg::OP_WRITE, pa, ra, d, x);
	endtask

	task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
		mc_u.xfer(pmr_pkg::OP_READ, pa, ra, 16'h0000, rv);
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		for (int p = 1; p <= 2; p++)
		begin
			rd(5'(p), 5'h02);
			check("id_upper", rv, ID_U);
			rd(5'(p), 5'h03);
			check("id_lower", rv, ID_L);
			rd(5'(p), 5'h04);
			check("advertise", rv, 16'h05E1);
			rd(5'(p), 5'h05);
			check("partner", rv, 16'h0000);
			rd(5'(p), 5'h1F);
			check("special", rv, 16'h0004);
		end
		rd(5'h02, 5'h1D);
		check("cable", rv, 16'h0000);
		check("adv_out", {6'h00, adv_out}, 16'h03FF);
		check("spc_out", {8'h00, spc_out}, 16'h0044);
		$display("Test reset values done");
	endtask

	task automatic t_ro();
		wr(5'h01, 5'h02, 16'hFFFF);
		wr(5'h01, 5'h03, 16'h0000);
		wr(5'h01, 5'h05, 16'hFFFF);
		rd(5'h01, 5'h02);
		check("id_upper", rv, ID_U);
		rd(5'h01, 5'h03);
		check("id_lower", rv, ID_L);
		rd(5'h01, 5'h05);
		check("partner", rv, 16'h0000);
		wr(5'h01, 5'h04, 16'hFFFF);
		rd(5'h01, 5'h04);
		check("adv_ones", rv, 16'h05E1);
		wr(5'h01, 5'h04, 16'h0000);
		rd(5'h01, 5'h04);
		check("adv_zero", rv, 16'h0001);
		check("adv_out", {6'h00, adv_out}, 16'h03E0);
		wr(5'h01, 5'h04, 16'h0420);
		check("adv_out", {6'h00, adv_out}, 16'h03F1);
		wr(5'h02, 5'h04, 16'h0180);
		rd(5'h02, 5'h04);
		check("adv2", rv, 16'h0181);
		check("adv_out", {6'h00, adv_out}, 16'h0191);
		$display("Test read-only and advertise done");
	endtask

	task automatic t_stat();
		stat <= {7'b1010110, 7'b0101001};
		rd(5'h02, 5'h05);
		check("partner2", rv, 16'h04A0);
		rd(5'h01, 5'h05);
		check("partner1", rv, 16'h0140);
		rd(5'h02, 5'h1F);
		check("polarity", rv, 16'h0024);
		rd(5'h01, 5'h1F);
		check("crossover", rv, 16'h0014);
		stat <= '0;
		$display("Test line status done");
	endtask

	task automatic t_spc();
		wr(5'h02, 5'h1F, 16'h003A);
		check("spc_out", {8'h00, spc_out}, 16'h00A4);
		rd(5'h02, 5'h1F);
		check("special", rv, 16'h000A);
		wr(5'h02, 5'h1F, 16'h0004);
		check("spc_out", {8'h00, spc_out}, 16'h0044);
		$display("Test special control done");
	endtask

	task automatic t_cable();
		int          n0;
		logic [15:0] e;
		n0 = n_starts;
		wr(5'h01, 5'h1D, 16'h8000);
		rd(5'h01, 5'h1D);
		check("cable_addr1", rv, 16'h0000);
		check("no_start", 16'(n_starts - n0), 16'h0000);
		for (int r = 0; r < 4; r++)
		begin
			n0 = n_starts;
			wr(5'h02, 5'h1D, 16'h8000);
			check("start", 16'(n_starts - n0), 16'h0001);
			rd(5'h02, 5'h1D);
			check("busy", {15'h0, rv[15]}, 16'h0001);
			cab <= '{1'b1, 2'(r), r[0], 9'(9'h100 + r)};
			@(posedge clk);
			cab.done <= 1'b0;
			e = {1'b0, 2'(r), r[0], 3'b000, 9'(9'h100 + r)};
			rd(5'h02, 5'h1D);
			check("result", rv, e);
		end
		$display("Test cable diagnostic done");
	endtask

	task automatic t_switch();
		int n0;
		sw <= '{1'b1, 1'b0, 5'b01010, 4'b1100, 1'b0};
		@(posedge clk);
		sw.wr <= 1'b0;
		rd(5'h01, 5'h04);
		check("sw_adv", rv, 16'h0141);
		rd(5'h01, 5'h1F);
		check("sw_spc", rv, 16'h000C);
		n0 = n_starts;
		sw <= '{1'b1, 1'b1, 5'h1F, 4'h4, 1'b1};
		@(posedge clk);
		sw.wr <= 1'b0;
		repeat (3) @(posedge clk);
		check("sw_start", 16'(n_starts - n0), 16'h0001);
		repeat (CAB_TO + 10) @(posedge clk);
		rd(5'h02, 5'h1D);
		check("timeout", rv, 16'h6000);
		$display("Test switch side done");
	endtask

	task automatic t_addr();
		mc_u.half = 6;
		wr(5'h03, 5'h04, 16'h0000);
		rd(5'h01, 5'h04);
		check("other_addr", rv, 16'h0141);
		rd(5'h03, 5'h02);
		check("no_drive", rv, 16'hFFFF);
		rd(5'h01, 5'h10);
		check("unmapped", rv, 16'h0000);
		$display("Test addressing done");
	endtask

	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		stat = '0;
		cab = '0;
		sw = '0;
		n_fail = 0;
		n_tests = 0;
		n_starts = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_ro();
		t_stat();
		t_spc();
		t_cable();
		t_switch();
		t_addr();
		give_verdict();
	end
endmodule // pmr_regs_tb
